/* File: core/ccr_clk_div.v */
// cycle tick from both edges of the input clock, and slow idle divider
// assumes the input clock level arrives already synchronised
`timescale 1ns/1ps
`include "ccr_defs.vh"
module ccr_clk_div (
    input wire aclk,
    input wire aresetn,
    input wire clk_level,
    input wire slow_en,
    input wire [1:0] div_sel,
    output reg cycle_tick,
    output reg slow_tick
);
    reg level_q;
    reg [7:0] count;
    wire edge_seen;
    wire [7:0] divisor;
    // ==========================================
    // both edges give two cycles per input period
    assign edge_seen = clk_level ^ level_q;
    assign divisor = `CCR_DIV_MIN << div_sel;
    always @(posedge aclk) begin
        if (!aresetn) begin
            level_q <= 1'b0;
            cycle_tick <= 1'b0;
        end else begin
            level_q <= clk_level;
            cycle_tick <= edge_seen;
        end
    end
    // ==========================================
    // divided tick, full rate outside slow idle
    always @(posedge aclk) begin
        if (!aresetn) begin
            count <= 8'h00;
            slow_tick <= 1'b0;
        end else if (!slow_en) begin
            count <= 8'h00;
            slow_tick <= edge_seen;
        end else if (edge_seen) begin
            if (count == divisor - 8'h01) begin
                count <= 8'h00;
                slow_tick <= 1'b1;
            end else begin
                count <= count + 8'h01;
                slow_tick <= 1'b0;
            end
        end else begin
            slow_tick <= 1'b0;
        end
    end
endmodule // ccr_clk_div

/* File: core/ccr_defs.vh */
// constants for the core clock, reset and mode control block
// assumes a 100 MHz aclk and an AXI4-Lite register master
// What this block does
// - sample memory-mode strap in reset, hold it
// - strap 0 full bus, 1 host port
// - full mode: upper data byte carries byte address
// - host mode strobes, open-drain ack, strap-chosen pull-down
// - slow idle divisor 16, 32, 64 or 128
// - slow idle divides serial, output, timer clocks
// - standard idle wakes within one cycle
// - slow idle wake delayed up to divisor cycles
// - cycle clock at twice input clock rate
// - cycle clock output, gated by disable bit
// - later resets need only minimum pulse width
// - reset empties stacks, masks interrupts, clears status
// - boot on release only without pending bus request
// - after boot fetch from address 0x0000, external when no boot mode strapped
// - strap pin is a flag pin after reset
// - host boot waits for write to program 0
`ifndef CCR_DEFS_VH
`define CCR_DEFS_VH
// ==========================================
// register map
`define CCR_REG_CTRL 8'h00
`define CCR_REG_STATUS 8'h04
`define CCR_REG_MODE_STATUS_REGISTER 8'h08
`define CCR_REG_IMASK 8'h0c
`define CCR_REG_STACK 8'h10
`define CCR_REG_FLAG 8'h14
// ==========================================
// control fields
`define CCR_CTRL_CLOCK_OUTPUT_DISABLE 0
`define CCR_CTRL_DIV_LO 1
`define CCR_CTRL_DIV_HI 2
`define CCR_CTRL_SLOW 3
`define CCR_CTRL_IDLE_GO 4
// ==========================================
// flag fields
`define CCR_FLAG_VALUE 0
`define CCR_FLAG_DIR 1
`define CCR_FLAG_PIN 2
// ==========================================
// reset values and widths
`define CCR_MODE_STATUS_REGISTER_W 7
`define CCR_MODE_STATUS_REGISTER_RST 7'h00
`define CCR_IMASK_RST 8'h00
`define CCR_STACK_EMPTY 4'h0
`define CCR_FETCH_START 14'h0000
`define CCR_DIV_MIN 8'h10
`define CCR_RESP_OKAY 2'b00
`define CCR_RESP_SLVERR 2'b10
`define CCR_PWRUP_INPUT_CLOCK_PIN 2000
`endif

/* File: core/ccr_strap.v */
// mode strap synchroniser and capture
// assumes straps are static around reset release
`timescale 1ns/1ps
`include "ccr_defs.vh"
module ccr_strap (
    input wire aclk,
    input wire aresetn,
    input wire [3:0] mode_pins,
    output reg [3:0] mode_q,
    output wire [3:0] pins_sync
);
    reg [3:0] sync1;
    reg [3:0] sync2;
    assign pins_sync = sync2;
    // ==========================================
    // two-stage sync, free of reset
    always @(posedge aclk) begin
        sync1 <= mode_pins;
        sync2 <= sync1;
    end
    // ==========================================
    // track while in reset, freeze at release
    always @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= sync2;
        end
    end
endmodule // ccr_strap

/* File: core/ccr_top.v */
// clocking, reset sequencing, strap mode and pin multiplexing
// assumes core-side requests on aclk, pins and strobes asynchronous
`timescale 1ns/1ps
`include "ccr_defs.vh"
module ccr_top #(
    parameter ADDR_W = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire input_clock_pin,
    input wire [3:0] mode_pins,
    output reg programmable_flag_two_out,
    output reg programmable_flag_two_oe_n,
    input wire bus_request_n,
    input wire bdma_boot_done,
    input wire [7:0] irq_req,
    input wire [13:0] core_addr,
    input wire [23:0] core_wdata,
    input wire core_drive,
    input wire byte_access,
    input wire [7:0] byte_addr_hi,
    output reg [13:0] external_address_bus,
    output reg [23:0] external_data_bus_out,
    output reg [23:0] external_data_bus_oe_n,
    input wire [15:0] host_addr_data_bus_in,
    input wire [15:0] host_read_data,
    output reg [15:0] host_addr_data_bus_out,
    output reg host_addr_data_bus_oe_n,
    input wire host_write_enable_n,
    input wire host_read_enable_n,
    input wire host_address_latch,
    input wire host_port_select_n,
    output reg host_port_acknowledge_out,
    output reg host_port_acknowledge_oe_n,
    output reg host_ack_pulldown_en,
    output reg host_mem_wr,
    output reg [15:0] host_mem_addr,
    output reg [15:0] host_mem_wdata,
    output reg cycle_clock_output,
    output reg serial_clock_tick,
    output reg timer_tick,
    output reg exec_enable,
    output reg idle_active,
    output reg boot_start,
    output reg fetch_external,
    output reg [13:0] fetch_addr,
    output reg stack_clear,
    output reg [`CCR_MODE_STATUS_REGISTER_W-1:0] mode_status_out,
    output reg [7:0] irq_mask_out
);
    localparam S_CHECK = 3'd0;
    localparam S_WBUS = 3'd1;
    localparam S_BDMA = 3'd2;
    localparam S_HOSTB = 3'd3;
    localparam S_RUN = 3'd4;
    localparam S_IDLE = 3'd5;
    localparam S_SIDLE = 3'd6;

    reg [2:0] state;
    reg [2:0] next_state;
    reg clock_output_disable;
    reg [1:0] idle_div;
    reg idle_slow;
    reg idle_go;
    reg wake_pend;
    reg [`CCR_MODE_STATUS_REGISTER_W-1:0] mode_status_register;
    reg [7:0] irq_mask;
    reg [3:0] stack_level;
    reg flag_value;
    reg flag_dir;
    reg clk_s1, clk_s2;
    reg br_s1, br_s2;
    reg [3:0] hs1, hs2, hs3;
    reg [15:0] hd1, hd2;
    reg [15:0] host_addr;
    reg aw_got, w_got;
    reg [ADDR_W-1:0] aw_q;
    reg [31:0] wd_q;
    reg wstrb0_q;
    reg [31:0] read_word;
    reg read_hit;
    wire [3:0] mode_q;
    wire [3:0] pins_sync;
    wire cycle_tick, slow_tick;
    wire host_mode, mode_d, boot_bdma, boot_host;
    wire irq_hit;
    wire host_sel, wr_fall, rd_act, wr_act;
    wire aw_take, w_take, ar_take, write_go;
    wire next_aw_got, next_w_got, next_bvalid, next_rvalid;

    // ==========================================
    // strap capture and clock divider
    ccr_strap u_strap (
        .aclk(aclk),
        .aresetn(aresetn),
        .mode_pins(mode_pins),
        .mode_q(mode_q),
        .pins_sync(pins_sync)
    );
    ccr_clk_div u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_level(clk_s2),
        .slow_en(state == S_SIDLE),
        .div_sel(idle_div),
        .cycle_tick(cycle_tick),
        .slow_tick(slow_tick)
    );

    // ==========================================
    // strap decode
    assign host_mode = mode_q[2];
    assign mode_d = mode_q[3];
    assign boot_bdma = (mode_q[1:0] == 2'b00) & ~(mode_q[2] & mode_q[1]);
    assign boot_host = mode_q[2] & (mode_q[1:0] == 2'b01);
    assign irq_hit = |(irq_req & irq_mask);

    // ==========================================
    // pin synchronisers
    always @(posedge aclk) begin
        clk_s1 <= input_clock_pin;
        clk_s2 <= clk_s1;
        br_s1 <= bus_request_n;
        br_s2 <= br_s1;
        hs1 <= {host_write_enable_n, host_read_enable_n, host_address_latch, host_port_select_n};
        hs2 <= hs1;
        hs3 <= hs2;
        hd1 <= host_addr_data_bus_in;
        hd2 <= hd1;
    end
    assign host_sel = ~hs2[0];
    assign wr_act = ~hs2[3] & host_sel;
    assign rd_act = ~hs2[2] & host_sel;
    assign wr_fall = wr_act & hs3[3];

    // ==========================================
    // boot and idle sequencing
    always @* begin
        next_state = state;
        case (state)
            S_CHECK: begin
                if (!br_s2) begin
                    next_state = S_WBUS;
                end else if (boot_host) begin
                    next_state = S_HOSTB;
                end else if (boot_bdma) begin
                    next_state = S_BDMA;
                end else begin
                    next_state = S_RUN;
                end
            end
            S_WBUS: begin
                if (br_s2) begin
                    next_state = S_CHECK;
                end
            end
            S_BDMA: begin
                if (bdma_boot_done) begin
                    next_state = S_RUN;
                end
            end
            S_HOSTB: begin
                if (wr_fall && host_mode && host_addr == 16'h0000) begin
                    next_state = S_RUN;
                end
            end
            S_RUN: begin
                if (idle_go) begin
                    next_state = idle_slow ? S_SIDLE : S_IDLE;
                end
            end
            S_IDLE: begin
                if (irq_hit) begin
                    next_state = S_RUN;
                end
            end
            S_SIDLE: begin
                if ((wake_pend || irq_hit) && slow_tick) begin
                    next_state = S_RUN;
                end
            end
            default: begin
                next_state = S_CHECK;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            state <= S_CHECK;
            wake_pend <= 1'b0;
            exec_enable <= 1'b0;
            idle_active <= 1'b0;
            boot_start <= 1'b0;
            fetch_external <= 1'b0;
            fetch_addr <= `CCR_FETCH_START;
            stack_clear <= 1'b1;
        end else begin
            state <= next_state;
            wake_pend <= (state == S_SIDLE) & (wake_pend | irq_hit) & ~slow_tick;
            exec_enable <= (next_state == S_RUN) | (next_state == S_IDLE) | (next_state == S_SIDLE);
            idle_active <= (next_state == S_IDLE) | (next_state == S_SIDLE);
            boot_start <= (state != S_BDMA) & (next_state == S_BDMA);
            fetch_external <= ~boot_bdma & ~boot_host;
            fetch_addr <= `CCR_FETCH_START;
            stack_clear <= 1'b0;
        end
    end

    // ==========================================
    // clock outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            cycle_clock_output <= 1'b0;
            serial_clock_tick <= 1'b0;
            timer_tick <= 1'b0;
        end else begin
            cycle_clock_output <= slow_tick & ~clock_output_disable;
            serial_clock_tick <= slow_tick;
            timer_tick <= slow_tick;
        end
    end

    // ==========================================
    // external bus multiplexing
    always @(posedge aclk) begin
        if (!aresetn) begin
            external_address_bus <= 14'h0000;
            external_data_bus_out <= 24'h000000;
            external_data_bus_oe_n <= 24'hffffff;
        end else if (!host_mode) begin
            external_address_bus <= core_addr;
            external_data_bus_out <= byte_access ? {byte_addr_hi, core_wdata[15:0]} : core_wdata;
            external_data_bus_oe_n[23:16] <= ~{8{core_drive | byte_access}};
            external_data_bus_oe_n[15:0] <= ~{16{core_drive}};
        end else begin
            external_address_bus <= {13'h0000, core_addr[0]};
            external_data_bus_out <= {core_wdata[15:0], 8'h00};
            external_data_bus_oe_n <= {~{16{core_drive}}, 8'hff};
        end
    end

    // ==========================================
    // host port
    always @(posedge aclk) begin
        if (!aresetn) begin
            host_addr <= 16'h0000;
            host_mem_wr <= 1'b0;
            host_mem_addr <= 16'h0000;
            host_mem_wdata <= 16'h0000;
            host_addr_data_bus_out <= 16'h0000;
            host_addr_data_bus_oe_n <= 1'b1;
            host_port_acknowledge_out <= 1'b0;
            host_port_acknowledge_oe_n <= 1'b1;
            host_ack_pulldown_en <= 1'b0;
        end else begin
            if (host_mode && host_sel && hs2[1]) begin
                host_addr <= hd2;
            end
            host_mem_wr <= host_mode & wr_fall;
            host_mem_addr <= host_addr;
            host_mem_wdata <= hd2;
            host_addr_data_bus_out <= host_read_data;
            host_addr_data_bus_oe_n <= ~(host_mode & rd_act);
            host_port_acknowledge_oe_n <= ~(host_mode & (wr_act | rd_act));
            host_ack_pulldown_en <= host_mode & ~mode_d;
        end
    end

    // ==========================================
    // programmable flag on the strap pin
    always @(posedge aclk) begin
        if (!aresetn) begin
            programmable_flag_two_out <= 1'b0;
            programmable_flag_two_oe_n <= 1'b1;
        end else begin
            programmable_flag_two_out <= flag_value;
            programmable_flag_two_oe_n <= ~flag_dir;
        end
    end

    // ==========================================
    // register bus, write side
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign write_go = aw_got & w_got & ~s_axi_bvalid;
    assign next_aw_got = (aw_got | aw_take) & ~write_go;
    assign next_w_got = (w_got | w_take) & ~write_go;
    assign next_bvalid = write_go | (s_axi_bvalid & ~s_axi_bready);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_q <= {ADDR_W{1'b0}};
            wd_q <= 32'h00000000;
            wstrb0_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CCR_RESP_OKAY;
            clock_output_disable <= 1'b0;
            idle_div <= 2'b00;
            idle_slow <= 1'b0;
            idle_go <= 1'b0;
            mode_status_register <= `CCR_MODE_STATUS_REGISTER_RST;
            irq_mask <= `CCR_IMASK_RST;
            stack_level <= `CCR_STACK_EMPTY;
            flag_value <= 1'b0;
            flag_dir <= 1'b0;
            mode_status_out <= `CCR_MODE_STATUS_REGISTER_RST;
            irq_mask_out <= `CCR_IMASK_RST;
        end else begin
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            s_axi_awready <= ~next_aw_got & ~next_bvalid;
            s_axi_wready <= ~next_w_got & ~next_bvalid;
            s_axi_bvalid <= next_bvalid;
            idle_go <= 1'b0;
            mode_status_out <= mode_status_register;
            irq_mask_out <= irq_mask;
            if (aw_take) begin
                aw_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wd_q <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0];
            end
            if (write_go) begin
                s_axi_bresp <= `CCR_RESP_OKAY;
                case (aw_q)
                    `CCR_REG_CTRL: begin
                        if (wstrb0_q) begin
                            clock_output_disable <= wd_q[`CCR_CTRL_CLOCK_OUTPUT_DISABLE];
                            idle_div <= wd_q[`CCR_CTRL_DIV_HI:`CCR_CTRL_DIV_LO];
                            idle_slow <= wd_q[`CCR_CTRL_SLOW];
                            idle_go <= wd_q[`CCR_CTRL_IDLE_GO] & (state == S_RUN);
                        end
                    end
                    `CCR_REG_STATUS: begin
                    end
                    `CCR_REG_MODE_STATUS_REGISTER: begin
                        if (wstrb0_q) begin
                            mode_status_register <= wd_q[`CCR_MODE_STATUS_REGISTER_W-1:0];
                        end
                    end
                    `CCR_REG_IMASK: begin
                        if (wstrb0_q) begin
                            irq_mask <= wd_q[7:0];
                        end
                    end
                    `CCR_REG_STACK: begin
                        if (wstrb0_q) begin
                            stack_level <= wd_q[3:0];
                        end
                    end
                    `CCR_REG_FLAG: begin
                        if (wstrb0_q) begin
                            flag_value <= wd_q[`CCR_FLAG_VALUE];
                            flag_dir <= wd_q[`CCR_FLAG_DIR];
                        end
                    end
                    default: begin
                        s_axi_bresp <= `CCR_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // ==========================================
    // register bus, read side
    always @* begin
        read_word = 32'h00000000;
        read_hit = 1'b1;
        case (s_axi_araddr)
            `CCR_REG_CTRL: read_word = {27'h0000000, idle_slow, idle_div, clock_output_disable, 1'b0} >> 1;
            `CCR_REG_STATUS: read_word = {21'h000000, cycle_tick, state, host_mode, mode_q, exec_enable, idle_active};
            `CCR_REG_MODE_STATUS_REGISTER: read_word = {25'h0000000, mode_status_register};
            `CCR_REG_IMASK: read_word = {24'h000000, irq_mask};
            `CCR_REG_STACK: read_word = {28'h0000000, stack_level};
            `CCR_REG_FLAG: read_word = {29'h00000000, pins_sync[2], flag_dir, flag_value};
            default: read_hit = 1'b0;
        endcase
    end

    assign ar_take = s_axi_arvalid & s_axi_arready;
    assign next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CCR_RESP_OKAY;
        end else begin
            s_axi_arready <= ~next_rvalid;
            s_axi_rvalid <= next_rvalid;
            if (ar_take) begin
                s_axi_rdata <= read_word;
                s_axi_rresp <= read_hit ? `CCR_RESP_OKAY : `CCR_RESP_SLVERR;
            end
        end
    end
endmodule // ccr_top

/* File: dv/ccr_board.sv */
// board model: free-running input clock and mode straps
// assumes strap value set by the bench before reset
`timescale 1ns/1ps
module ccr_board (
    input wire aresetn,
    input wire [3:0] strap,
    output reg input_clock_pin,
    output wire [3:0] mode_pins
);
initial input_clock_pin = 1'b0;
// constant rate, never halted
always #30 input_clock_pin = ~input_clock_pin;
// straps valid in reset only, then inverted to expose late sampling
assign mode_pins = aresetn ? ~strap : strap;
endmodule // ccr_board

/* File: dv/ccr_monitor.sv */
// assertion checker for the clock, reset and mode block
// assumes bind to ccr_top, single aclk domain
`timescale 1ns/1ps
`include "ccr_defs.vh"
module ccr_monitor (
    input wire aclk,
    input wire aresetn,
    input wire input_clock_pin,
    input wire bus_request_n,
    input wire [7:0] irq_req,
    input wire host_port_acknowledge_out,
    input wire host_port_acknowledge_oe_n,
    input wire host_ack_pulldown_en,
    input wire cycle_clock_output,
    input wire serial_clock_tick,
    input wire timer_tick,
    input wire idle_active,
    input wire boot_start,
    input wire exec_enable,
    input wire [13:0] fetch_addr,
    input wire stack_clear,
    input wire [`CCR_MODE_STATUS_REGISTER_W-1:0] mode_status_out,
    input wire [7:0] irq_mask_out
);
// ==========================================
// cycles since reset release
reg [2:0] run_cnt;
always @(posedge aclk) begin
    if (!aresetn)
        run_cnt <= 3'h0;
    else if (run_cnt != 3'h7)
        run_cnt <= run_cnt + 3'h1;
end
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
// ==========================================
// properties
AST_RST_CLEAR: assert property ($rose(aresetn) |-> stack_clear && mode_status_out == 0 && irq_mask_out == 0)
    else $error("reset state not cleared");
AST_STRAP_HOLD: assert property (run_cnt == 3'h7 |-> $stable(host_ack_pulldown_en))
    else $error("strap mode changed while running");
AST_TICK_SAME: assert property (timer_tick == serial_clock_tick)
    else $error("timer and serial ticks differ");
AST_CLKO_TICK: assert property (cycle_clock_output |-> serial_clock_tick)
    else $error("clock output off the cycle tick");
AST_CYCLE_RATE: assert property ($changed(input_clock_pin) |-> ##[1:4] (serial_clock_tick || idle_active))
    else $error("no cycle per input edge");
AST_WAKE: assert property (idle_active && (irq_req & irq_mask_out) != 8'h00 |-> ##[1:500] !idle_active)
    else $error("idle wake too late");
AST_NO_BOOT: assert property (!bus_request_n [*5] |-> !boot_start)
    else $error("boot with bus request pending");
AST_FETCH: assert property (exec_enable |-> fetch_addr == 14'h0000)
    else $error("first fetch address wrong");
AST_ACK_OD: assert property (!host_port_acknowledge_oe_n |-> !host_port_acknowledge_out)
    else $error("acknowledge driven high");
endmodule // ccr_monitor

/* File: dv/ccr_top_bench.sv */
// self-checking bench for ccr_top
// assumes ccr_board as board model and ccr_monitor bound in
`timescale 1ns/1ps
`include "ccr_defs.vh"
`define CHK(g, e) begin n_tests = n_tests + 1; if ((g) !== (e)) begin mismatches = mismatches + 1; \
    $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
`define WT(c) begin wi = 0; while (!(c) && wi < 600) begin @(posedge aclk); wi = wi + 1; end if (wi == 600) tmo; end
module ccr_top_bench;
reg aclk = 0, aresetn = 0;
reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, irq_req = 0, byte_addr_hi = 0;
reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
reg [31:0] s_axi_wdata = 0, rdat;
reg [3:0] s_axi_wstrb = 4'hf, strap = 4'h2;
reg bus_request_n = 1, bdma_boot_done = 0, core_drive = 0, byte_access = 0, b;
reg [13:0] core_addr = 0;
reg [23:0] core_wdata = 0;
reg [15:0] host_addr_data_bus_in = 0, host_read_data = 0;
reg host_write_enable_n = 1, host_read_enable_n = 1, host_address_latch = 0, host_port_select_n = 1;
reg [1:0] rrsp;
integer mismatches = 0, n_tests = 0, wi, k, g;
wire input_clock_pin, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire programmable_flag_two_out, programmable_flag_two_oe_n, host_addr_data_bus_oe_n, host_mem_wr;
wire host_port_acknowledge_out, host_port_acknowledge_oe_n, host_ack_pulldown_en, cycle_clock_output;
wire serial_clock_tick, timer_tick, exec_enable, idle_active, boot_start, fetch_external, stack_clear;
wire [3:0] mode_pins;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
wire [13:0] external_address_bus, fetch_addr;
wire [23:0] external_data_bus_out, external_data_bus_oe_n;
wire [15:0] host_addr_data_bus_out, host_mem_addr, host_mem_wdata;
wire [`CCR_MODE_STATUS_REGISTER_W-1:0] mode_status_out;
wire [7:0] irq_mask_out;
ccr_top ccr_top_inst (.*);
ccr_board ccr_board_inst (.*);
always #5 aclk = ~aclk;
// ==========================================
// common tasks
task complete_run;
    begin
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    end
endtask
task tmo;
    begin
        mismatches = mismatches + 1;
        complete_run;
    end
endtask
task rst(input [3:0] s);
    begin
        strap <= s;
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
    end
endtask
task wr(input [7:0] a, input [31:0] d);
    integer i;
    begin
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 99; i = i + 1) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) i = 200;
        end
        if (i == 99) tmo;
    end
endtask
task rd(input [7:0] a);
    integer i;
    begin
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 99; i = i + 1) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                rdat = s_axi_rdata;
                rrsp = s_axi_rresp;
                i = 200;
            end
        end
        if (i == 99) tmo;
    end
endtask
// ==========================================
// scenarios
task t_regs;
    begin
        wr(8'h08, 32'h7f);
        wr(8'h0c, 32'hff);
        wr(8'h10, 32'hf);
        rst(4'h2);
        for (k = 8; k <= 16; k = k + 4) begin
            rd(k[7:0]);
            `CHK(rdat, 32'h0)
        end
        `CHK({mode_status_out, irq_mask_out}, 15'h0)
        rd(8'h18);
        `CHK(rrsp, `CCR_RESP_SLVERR)
        rd(8'h04);
        `CHK(rdat[6:2], 5'h02)
        `CHK({fetch_external, fetch_addr}, 15'h4000)
        wr(8'h14, 32'h3);
        rd(8'h14);
        `CHK({rdat[2:0], programmable_flag_two_out, programmable_flag_two_oe_n}, 5'b11110)
        core_addr <= 14'h2abd;
        core_drive <= 1'b1;
        byte_access <= 1'b1;
        byte_addr_hi <= 8'ha5;
        `WT(external_data_bus_out[23:16] === 8'ha5)
        `CHK(external_data_bus_out[23:16], 8'ha5)
        `CHK(external_address_bus, 14'h2abd)
    end
endtask
task t_idle;
    integer n;
    begin
        wr(8'h0c, 32'h1);
        for (n = 0; n < 4; n = n + 1) begin
            wr(8'h00, 32'h18 | (n << 1) | (n & 1));
            `WT(idle_active)
            `WT(serial_clock_tick)
            @(posedge aclk);
            `WT(serial_clock_tick)
            g = 0;
            b = 0;
            do begin
                @(posedge aclk);
                g = g + 1;
                b = b | cycle_clock_output;
            end while (!serial_clock_tick && g < 999);
            `CHK(g, (16 << n) * 3)
            `CHK(b, ~n[0])
            irq_req <= 8'h01;
            `WT(!idle_active)
            `CHK(wi <= (16 << n) * 3 + 6, 1'b1)
            irq_req <= 8'h00;
        end
        wr(8'h00, 32'h10);
        `WT(idle_active)
        irq_req <= 8'h01;
        repeat (2) @(posedge aclk);
        `CHK(idle_active, 1'b0)
        irq_req <= 8'h00;
    end
endtask
task t_boot;
    begin
        bus_request_n <= 1'b0;
        rst(4'h0);
        b = 0;
        repeat (20) begin
            @(posedge aclk);
            b = b | boot_start;
        end
        `CHK(b, 1'b0)
        bus_request_n <= 1'b1;
        `WT(boot_start)
        `CHK(exec_enable, 1'b0)
        bdma_boot_done <= 1'b1;
        `WT(exec_enable)
        `CHK(fetch_addr, 14'h0000)
        bdma_boot_done <= 1'b0;
    end
endtask
task t_host;
    begin
        rst(4'h5);
        `CHK({host_ack_pulldown_en, exec_enable}, 2'b10)
        rd(8'h04);
        `CHK(rdat[6], 1'b1)
        `CHK(external_address_bus, 14'h0001)
        host_port_select_n <= 1'b0;
        host_address_latch <= 1'b1;
        repeat (4) @(posedge aclk);
        host_address_latch <= 1'b0;
        host_addr_data_bus_in <= 16'h1234;
        host_write_enable_n <= 1'b0;
        `WT(host_mem_wr)
        `CHK({host_mem_addr, host_mem_wdata}, 32'h00001234)
        `CHK(host_port_acknowledge_oe_n, 1'b0)
        host_write_enable_n <= 1'b1;
        host_port_select_n <= 1'b1;
        `WT(exec_enable)
        `CHK(exec_enable, 1'b1)
    end
endtask
initial begin
    rst(4'h2);
    t_regs;
    t_idle;
    t_boot;
    t_host;
    complete_run;
end
endmodule // ccr_top_bench
bind ccr_top ccr_monitor ccr_monitor_inst (.*);
